// ---- common/pps_pkg.sv ----
package pps_pkg;

    // Data path and silo shape
    localparam int PPS_DW         = 16;               // Parallel data width
    localparam int PPS_SILO_DEPTH = 32;               // Silo depth in words
    localparam int PPS_CNT_W      = 6;                // Fill count width, holds 0..32
    localparam int PPS_AW         = 8;                // APB byte address width

    // Register byte offsets
    localparam logic [7:0] PPS_CSR_OFS  = 8'h00;      // Control/status
    localparam logic [7:0] PPS_OBUF_OFS = 8'h04;      // Output buffer
    localparam logic [7:0] PPS_IBUF_OFS = 8'h08;      // Input buffer
    localparam logic [7:0] PPS_MISC_OFS = 8'h0c;      // Mode and silo fill

    // Control/status bit positions
    localparam int PPS_CSR_CTL0  = 0;                 // Control zero line
    localparam int PPS_CSR_CTL1  = 1;                 // Control one line
    localparam int PPS_CSR_IEB   = 5;                 // Interrupt enable B
    localparam int PPS_CSR_IEA   = 6;                 // Interrupt enable A
    localparam int PPS_CSR_REQA  = 7;                 // Request A status
    localparam int PPS_CSR_FLUSH = 11;                // Flush, write one, reads zero
    localparam int PPS_CSR_REQB  = 15;                // Request B status

    // Misc register fields
    localparam int PPS_MISC_MODE_LSB = 0;             // Mode field, 4 bits
    localparam int PPS_MISC_CNT_LSB  = 8;             // Silo fill count

    // Mode codes
    localparam logic [3:0] PPS_MODE_BASIC = 4'h0;     // Programmed transfer
    localparam logic [3:0] PPS_MODE_TX_A  = 4'h5;     // Transmit silo, A requests
    localparam logic [3:0] PPS_MODE_RX_A  = 4'h7;     // Receive silo, A requests

    // Values after reset
    localparam logic [3:0]        PPS_MODE_RST = 4'h0;
    localparam logic [PPS_DW-1:0] PPS_DATA_RST = 16'h0000;

    // Operating kind decoded from the mode field
    typedef enum logic [2:0] {
        PPS_KIND_BASIC,
        PPS_KIND_SILO_RX,
        PPS_KIND_SILO_TX,
        PPS_KIND_DMA,
        PPS_KIND_RSVD
    } pps_kind_e;

    // Mode decode shared by all mode-dependent logic
    function automatic pps_kind_e pps_mode_kind(input logic [3:0] m);
        pps_kind_e k;
        k = PPS_KIND_RSVD;
        if (m == PPS_MODE_BASIC) begin
            k = PPS_KIND_BASIC;
        end else if (m == PPS_MODE_RX_A) begin
            k = PPS_KIND_SILO_RX;
        end else if (m == PPS_MODE_TX_A) begin
            k = PPS_KIND_SILO_TX;
        end else if (m[3]) begin
            k = PPS_KIND_DMA;
        end
        return k;
    endfunction

endpackage

// ---- common/pps_silo_if.sv ----
`timescale 1ns/10ps
// Port logic to silo storage
interface pps_silo_if;
    logic                          push;   // Enqueue wdata
    logic                          pop;    // Drop oldest word
    logic                          flush;  // Discard everything
    logic [pps_pkg::PPS_DW-1:0]    wdata;  // Word to enqueue
    logic [pps_pkg::PPS_DW-1:0]    rdata;  // Oldest word
    logic                          full;   // No room left
    logic                          empty;  // Nothing held
    logic [pps_pkg::PPS_CNT_W-1:0] count;  // Words held

    modport ctl  (output push, pop, flush, wdata, input rdata, full, empty, count);
    modport silo (input push, pop, flush, wdata, output rdata, full, empty, count);
endinterface

// ---- hw/pps_silo.sv ----
`timescale 1ns/10ps
// Word silo; DEPTH must be a power of two so the pointers wrap by overflow
module pps_silo #(
    parameter int DEPTH = pps_pkg::PPS_SILO_DEPTH
) (
    input wire logic  clk,
    input wire logic  rst_n,
    pps_silo_if.silo  sif
);
    localparam int AW = $clog2(DEPTH);

    logic [pps_pkg::PPS_DW-1:0] mem [DEPTH];  // Storage, no reset needed
    logic [AW-1:0]              wr_ptr_reg;   // Next free slot
    logic [AW-1:0]              rd_ptr_reg;   // Oldest word
    logic [AW:0]                cnt_reg;      // Words held
    logic                       do_push;      // Accepted enqueue
    logic                       do_pop;       // Accepted dequeue

    // Refuse overflow and underflow here as well as in the caller
    assign do_push = sif.push & (cnt_reg != (AW+1)'(DEPTH));
    assign do_pop  = sif.pop & (cnt_reg != '0);

    // Word storage
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= sif.wdata;
        end
    end

    // Pointers and fill count; flush empties the silo at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else if (sif.flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_push && !do_pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    assign sif.rdata = mem[rd_ptr_reg];
    assign sif.full  = (cnt_reg == (AW+1)'(DEPTH));
    assign sif.empty = (cnt_reg == '0);
    assign sif.count = pps_pkg::PPS_CNT_W'(cnt_reg);
endmodule

// ---- hw/pps_port.sv ----
`timescale 1ns/10ps
module pps_port (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [pps_pkg::PPS_AW-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [pps_pkg::PPS_DW-1:0]  din,
    input  wire logic                        req_a,
    input  wire logic                        req_b,
    output logic      [pps_pkg::PPS_DW-1:0]  dout,
    output logic                             data_xmit,
    output logic                             new_data,
    output logic                             ctrl0,
    output logic                             ctrl1,
    output logic                             irq_a,
    output logic                             irq_b
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    pps_silo_if sif ();

    // Bus side state
    logic [31:0]                 prdata_reg;   // Read data, captured at setup
    logic                        pready_reg;   // High for exactly the access cycle
    logic                        pslverr_reg;  // Unmapped address flag
    // Software visible control
    logic                        ctl0_reg;     // Control zero line
    logic                        ctl1_reg;     // Control one line
    logic                        iea_reg;      // Interrupt enable A
    logic                        ieb_reg;      // Interrupt enable B
    logic [3:0]                  mode_reg;     // Operating mode
    logic [pps_pkg::PPS_DW-1:0]  obuf_reg;     // Last word software wrote
    // Line side state
    logic [pps_pkg::PPS_DW-1:0]  dout_reg;     // Output lines
    logic                        dt_reg;       // Data Transmitted pulse
    logic                        nd_reg;       // New Data Ready pulse
    logic                        irq_a_reg;    // Vector A request pulse
    logic                        irq_b_reg;    // Vector B request pulse
    logic                        reqa_stat_reg; // Request A status bit
    // Request synchronisers and edge history
    logic                        reqa_meta_reg;
    logic                        reqa_sync_reg;
    logic                        reqa_prev_reg;
    logic                        reqb_meta_reg;
    logic                        reqb_sync_reg;
    logic                        reqb_prev_reg;

    pps_pkg::pps_kind_e kind;     // Decoded mode
    logic               setup;    // APB setup cycle
    logic               done;     // APB transfer completes this edge
    logic               wr_ok;    // Mapped write completes
    logic               rd_ok;    // Mapped read completes
    logic               wr_csr;   // CSR written
    logic               wr_ob;    // Output buffer written
    logic               wr_misc;  // Mode register written
    logic               rd_ib;    // Input buffer read
    logic               is_basic; // Programmed transfer mode
    logic               is_rx;    // Receive silo
    logic               is_tx;    // Transmit silo
    logic               edge_a;   // Any toggle of request A
    logic               edge_b;   // Any toggle of request B
    logic               rise_a;   // Rising edge of request A
    logic               rise_b;   // Rising edge of request B
    logic               push_rx;  // Line word enters receive silo
    logic               push_tx;  // Software word enters transmit silo
    logic               pop_tx;   // Silo word goes out to the lines
    logic               pop_rx;   // Software takes oldest received word
    logic               xfer_a;   // A transfer moved a word
    logic               flush;    // Flush request
    logic [31:0]        csr_view; // CSR read value

    // Address decode, used at setup; completion uses its registered result in pslverr_reg
    function automatic logic pps_mapped(input logic [pps_pkg::PPS_AW-1:0] a);
        return (a == pps_pkg::PPS_CSR_OFS) || (a == pps_pkg::PPS_OBUF_OFS) ||
               (a == pps_pkg::PPS_IBUF_OFS) || (a == pps_pkg::PPS_MISC_OFS);
    endfunction

    // Mode decode; DMA codes are stored but move no data in this port
    assign kind     = pps_pkg::pps_mode_kind(mode_reg);
    assign is_basic = (kind == pps_pkg::PPS_KIND_BASIC);
    assign is_rx    = (kind == pps_pkg::PPS_KIND_SILO_RX);
    assign is_tx    = (kind == pps_pkg::PPS_KIND_SILO_TX);

    // Bus phase decode
    assign setup   = psel & ~penable;
    assign done    = psel & penable & pready_reg;
    assign wr_ok   = done & pwrite & ~pslverr_reg;
    assign rd_ok   = done & ~pwrite & ~pslverr_reg;
    assign wr_csr  = wr_ok & (paddr == pps_pkg::PPS_CSR_OFS);
    assign wr_ob   = wr_ok & (paddr == pps_pkg::PPS_OBUF_OFS);
    assign wr_misc = wr_ok & (paddr == pps_pkg::PPS_MISC_OFS);
    assign rd_ib   = rd_ok & (paddr == pps_pkg::PPS_IBUF_OFS);

    // Edges come only from synchronised samples, one event per toggle
    assign edge_a = reqa_sync_reg ^ reqa_prev_reg;
    assign edge_b = reqb_sync_reg ^ reqb_prev_reg;
    assign rise_a = reqa_sync_reg & ~reqa_prev_reg;
    assign rise_b = reqb_sync_reg & ~reqb_prev_reg;

    // Silo traffic; a refused word simply never happened
    assign push_rx = is_rx & edge_a & ~sif.full;
    assign push_tx = is_tx & wr_ob & ~sif.full;
    assign pop_tx  = is_tx & edge_a & ~sif.empty;
    assign pop_rx  = is_rx & rd_ib & ~sif.empty;
    assign xfer_a  = push_rx | pop_tx;
    assign flush   = wr_csr & pwdata[pps_pkg::PPS_CSR_FLUSH];

    assign sif.push  = push_rx | push_tx;
    assign sif.pop   = pop_rx | pop_tx;
    assign sif.flush = flush;
    assign sif.wdata = is_rx ? din : pwdata[pps_pkg::PPS_DW-1:0];

    // CSR read image; unused bits read as zero
    always_comb begin
        csr_view = 32'h0000_0000;
        csr_view[pps_pkg::PPS_CSR_CTL0] = ctl0_reg;
        csr_view[pps_pkg::PPS_CSR_CTL1] = ctl1_reg;
        csr_view[pps_pkg::PPS_CSR_IEB]  = ieb_reg;
        csr_view[pps_pkg::PPS_CSR_IEA]  = iea_reg;
        csr_view[pps_pkg::PPS_CSR_REQA] = reqa_stat_reg;
        csr_view[pps_pkg::PPS_CSR_REQB] = reqb_sync_reg;
    end

    pps_silo #(
        .DEPTH (pps_pkg::PPS_SILO_DEPTH)
    ) u_silo (
        .clk   (clk),
        .rst_n (rst_n),
        .sif   (sif)
    );

    // APB handshake: one wait-free access cycle after every setup
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup & ~pps_mapped(paddr);
        end
    end

    // Read data is captured at setup so the input lines are taken at the read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            case (paddr)
                pps_pkg::PPS_CSR_OFS: begin
                    prdata_reg <= csr_view;
                end
                pps_pkg::PPS_OBUF_OFS: begin
                    prdata_reg <= {16'h0000, obuf_reg};
                end
                pps_pkg::PPS_IBUF_OFS: begin
                    if (is_rx) begin
                        // Empty silo reads as zero rather than stale storage
                        prdata_reg <= {16'h0000, sif.empty ? 16'h0000 : sif.rdata};
                    end else begin
                        prdata_reg <= {16'h0000, din};
                    end
                end
                pps_pkg::PPS_MISC_OFS: begin
                    prdata_reg <= {18'h00000, sif.count, 4'h0, mode_reg};
                end
                default: begin
                    prdata_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Control register; flush is a strobe and is not stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl0_reg <= 1'b0;
            ctl1_reg <= 1'b0;
            iea_reg  <= 1'b0;
            ieb_reg  <= 1'b0;
        end else if (wr_csr) begin
            ctl0_reg <= pwdata[pps_pkg::PPS_CSR_CTL0];
            ctl1_reg <= pwdata[pps_pkg::PPS_CSR_CTL1];
            iea_reg  <= pwdata[pps_pkg::PPS_CSR_IEA];
            ieb_reg  <= pwdata[pps_pkg::PPS_CSR_IEB];
        end
    end

    // Mode register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= pps_pkg::PPS_MODE_RST;
        end else if (wr_misc) begin
            mode_reg <= pwdata[pps_pkg::PPS_MISC_MODE_LSB +: 4];
        end
    end

    // Output buffer keeps the last write in every mode for readback
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            obuf_reg <= pps_pkg::PPS_DATA_RST;
        end else if (wr_ob) begin
            obuf_reg <= pwdata[pps_pkg::PPS_DW-1:0];
        end
    end

    // Output lines: buffer in basic mode, silo head on each transmit request that finds the silo not empty
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_reg <= pps_pkg::PPS_DATA_RST;
        end else if (is_basic && wr_ob) begin
            dout_reg <= pwdata[pps_pkg::PPS_DW-1:0];
        end else if (pop_tx) begin
            dout_reg <= sif.rdata;
        end
    end

    // Line strobes; a refused receive word gets no pulse at all
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dt_reg <= 1'b0;
            nd_reg <= 1'b0;
        end else begin
            dt_reg <= (is_basic & rd_ib) | push_rx;
            nd_reg <= (is_basic & wr_ob) | pop_tx;
        end
    end

    // Request synchronisers; the first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reqa_meta_reg <= 1'b0;
            reqa_sync_reg <= 1'b0;
            reqa_prev_reg <= 1'b0;
            reqb_meta_reg <= 1'b0;
            reqb_sync_reg <= 1'b0;
            reqb_prev_reg <= 1'b0;
        end else begin
            reqa_meta_reg <= req_a;
            reqa_sync_reg <= reqa_meta_reg;
            reqa_prev_reg <= reqa_sync_reg;
            reqb_meta_reg <= req_b;
            reqb_sync_reg <= reqb_meta_reg;
            reqb_prev_reg <= reqb_sync_reg;
        end
    end

    // Request A status follows the line, but in silo mode only once a word moved
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reqa_stat_reg <= 1'b0;
        end else if (!(is_rx || is_tx)) begin
            reqa_stat_reg <= reqa_sync_reg;
        end else if (xfer_a) begin
            reqa_stat_reg <= reqa_sync_reg;
        end
    end

    // Interrupt requests as one-cycle pulses toward the vector logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_a_reg <= 1'b0;
            irq_b_reg <= 1'b0;
        end else begin
            if (is_basic) begin
                irq_a_reg <= iea_reg & rise_a;
                irq_b_reg <= ieb_reg & rise_b;
            end else begin
                // Each moved word interrupts, whether or not the status bit changes
                irq_a_reg <= iea_reg & xfer_a;
                irq_b_reg <= ieb_reg & edge_b;
            end
        end
    end

    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
    assign dout      = dout_reg;
    assign data_xmit = dt_reg;
    assign new_data  = nd_reg;
    assign ctrl0     = ctl0_reg;
    assign ctrl1     = ctl1_reg;
    assign irq_a     = irq_a_reg;
    assign irq_b     = irq_b_reg;

    // Checks on the block's own behaviour
    property p_dt_basic;
        is_basic && rd_ib |=> data_xmit ##1 !data_xmit;
    endproperty
    a_dt_basic: assert property (p_dt_basic) else $error("No Data Transmitted pulse after read");

    property p_ib_sample;
        is_basic && setup && !pwrite && paddr == pps_pkg::PPS_IBUF_OFS
            |=> prdata[15:0] == $past(din) && pready;
    endproperty
    a_ib_sample: assert property (p_ib_sample) else $error("Input read not sampled at read");

    property p_dout_basic;
        is_basic && wr_ob |=> dout == $past(pwdata[15:0]) && new_data;
    endproperty
    a_dout_basic: assert property (p_dout_basic) else $error("Output lines miss written word");

    property p_irq_a_basic;
        is_basic && iea_reg && rise_a |=> irq_a;
    endproperty
    a_irq_a_basic: assert property (p_irq_a_basic) else $error("Rising request A lost");

    property p_full_refuse;
        is_rx && edge_a && sif.full && !pop_rx && !flush |=> !data_xmit && sif.full;
    endproperty
    a_full_refuse: assert property (p_full_refuse) else $error("Full silo accepted a word");

    property p_rx_push;
        is_rx && edge_a && !sif.full && !rd_ib && !flush
            |=> data_xmit && sif.count == $past(sif.count) + 6'h01;
    endproperty
    a_rx_push: assert property (p_rx_push) else $error("Receive edge did not enqueue");

    property p_flush;
        flush |=> sif.empty && sif.count == 6'h00;
    endproperty
    a_flush: assert property (p_flush) else $error("Flush left words in silo");

    property p_irq_b_silo;
        !is_basic && ieb_reg && edge_b |=> irq_b;
    endproperty
    a_irq_b_silo: assert property (p_irq_b_silo) else $error("Silo mode B edge lost");

    property p_stat_silo;
        is_rx && !xfer_a && $stable(mode_reg) |=> $stable(reqa_stat_reg);
    endproperty
    a_stat_silo: assert property (p_stat_silo) else $error("Status A moved without a word");

    c_rx_push:  cover property (push_rx ##1 data_xmit);
    c_full:     cover property (is_rx && edge_a && sif.full);
    c_tx_pop:   cover property (pop_tx ##1 new_data);
    c_flush:    cover property (flush && !sif.empty);
endmodule

// ---- testbench/pps_user_dev.sv ----
`timescale 1ns/10ps
// User device model; it alone drives the request lines and the input data
module pps_user_dev (
    input  wire logic        clk,
    input  wire logic        data_xmit,
    output logic      [15:0] din,
    output logic             req_a,
    output logic             req_b,
    output int               taken
);
    // Lines start low
    initial begin
        din = 16'h0000;
        req_a = 1'b0;
        req_b = 1'b0;
        taken = 0;
    end

    // A word counts as taken only on a Data Transmitted pulse
    always @(posedge clk) begin
        taken += (data_xmit === 1'b1);
    end

    // Present a word and toggle request A as the transfer request
    task automatic send(input logic [15:0] w);
        @(posedge clk);
        din <= w;
        req_a <= ~req_a;
        repeat (6) @(posedge clk);
    endtask

    // Toggle request B; the wait covers the port's synchroniser
    task automatic flip_b();
        @(posedge clk);
        req_b <= ~req_b;
        repeat (6) @(posedge clk);
    endtask
endmodule

// ---- testbench/parallel_io_port_silo_tb.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module parallel_io_port_silo_tb;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        req_a, req_b, data_xmit, new_data, ctrl0, ctrl1, irq_a, irq_b;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] din, dout;
    int          num_checks = 0, fails = 0, n_nd = 0, n_ia = 0, n_ib = 0, cyc = 0, taken;

    pps_port DUT (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .din, .req_a, .req_b, .dout, .data_xmit, .new_data,
        .ctrl0, .ctrl1, .irq_a, .irq_b);
    pps_user_dev dev (.clk, .data_xmit, .din, .req_a, .req_b, .taken);

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Pulse counters; the cycle ceiling cuts a hung handshake short
    always @(posedge clk) begin
        n_nd += (new_data === 1'b1);
        n_ia += (irq_a === 1'b1);
        n_ib += (irq_b === 1'b1);
        cyc++;
        if (cyc == 4000) begin
            fails++;
            final_report();
        end
    end

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic final_report();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // Basic mode
        apb(1'b1, pps_pkg::PPS_OBUF_OFS, 32'h0000a55a);
        repeat (2) @(posedge clk);
        `CHK({dout, n_nd}, {16'ha55a, 32'd1})
        apb(1'b1, pps_pkg::PPS_CSR_OFS, 32'h00000063);
        dev.send(16'h1234);
        dev.flip_b();
        apb(1'b0, pps_pkg::PPS_CSR_OFS, 32'h0);
        `CHK({rd, ctrl0, ctrl1, n_ia, n_ib}, {32'h80e3, 2'b11, 32'd1, 32'd1})
        apb(1'b0, pps_pkg::PPS_IBUF_OFS, 32'h0);
        `CHK(rd, 32'h00001234)
        dev.send(16'h5678);
        `CHK({taken, n_ia}, {32'd1, 32'd1})
        apb(1'b0, 8'h10, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        $display("test basic done");
        // Receive silo; the 33rd request meets a full silo
        apb(1'b1, pps_pkg::PPS_MISC_OFS, 32'h00000007);
        for (int i = 0; i < 33; i++) dev.send(16'h0100 + 16'(i));
        dev.flip_b();
        `CHK({taken, n_ia, n_ib}, {32'd33, 32'd33, 32'd2})
        // Line A is high now, but the refused word left the status bit low
        apb(1'b0, pps_pkg::PPS_CSR_OFS, 32'h0);
        `CHK(rd, 32'h00000063)
        apb(1'b0, pps_pkg::PPS_MISC_OFS, 32'h0);
        `CHK(rd, 32'h00002007)
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, pps_pkg::PPS_IBUF_OFS, 32'h0);
            `CHK(rd, 32'h00000100 + 32'(i))
        end
        apb(1'b1, pps_pkg::PPS_CSR_OFS, 32'h00000861);
        apb(1'b0, pps_pkg::PPS_MISC_OFS, 32'h0);
        `CHK(rd, 32'h00000007)
        $display("test receive silo done");
        // Transmit silo; the third request finds it empty
        apb(1'b1, pps_pkg::PPS_MISC_OFS, 32'h00000005);
        apb(1'b1, pps_pkg::PPS_OBUF_OFS, 32'h0000c0de);
        apb(1'b1, pps_pkg::PPS_OBUF_OFS, 32'h0000d00d);
        dev.send(16'h0);
        `CHK(dout, 16'hc0de)
        dev.send(16'h0);
        dev.send(16'h0);
        `CHK({dout, n_nd, n_ia}, {16'hd00d, 32'd3, 32'd35})
        $display("test transmit silo done");
        // DMA code is only stored: line A moves nothing, line B still interrupts
        apb(1'b1, pps_pkg::PPS_MISC_OFS, 32'h00000009);
        dev.send(16'h0);
        dev.flip_b();
        apb(1'b0, pps_pkg::PPS_CSR_OFS, 32'h0);
        `CHK({rd, taken, n_ia, n_ib}, {32'h80e1, 32'd33, 32'd35, 32'd3})
        $display("test dma code done");
        final_report();
    end
endmodule
